// >>> rtl/xide_defines.vh
`ifndef XIDE_DEFINES_VH
`define XIDE_DEFINES_VH
`define XIDE_OP_REG_HI 5'h0d
`define XIDE_OP_DIR 8'h65
`define XIDE_OP_IND_HI 7'h33
`define XIDE_OP_IMM 8'h64
`define XIDE_OP_DST 8'h62
`define XIDE_ADDR_W 16
`define XIDE_PROG_ONCHIP_SMALL 16'h1000
`define XIDE_PROG_ONCHIP_LARGE 16'h2000
`define XIDE_RAM_SMALL 9'h080
`define XIDE_RAM_LARGE 9'h100
`define XIDE_SFR_BASE 8'h80
`define XIDE_SFR_ACC 8'he0
`define XIDE_SFR_P0 8'h80
`define XIDE_SFR_P1 8'h90
`define XIDE_SFR_P2 8'ha0
`define XIDE_SFR_P3 8'hb0
`define XIDE_ZERO_BYTE 8'h00
`define XIDE_ZERO_WORD 16'h0000
`define XIDE_REG_PAD 3'h0
`define XIDE_PTR_PAD 2'h0
`define XIDE_ST_FETCH 2'h0
`define XIDE_ST_OPER 2'h1
`define XIDE_ST_EXEC 2'h2
`endif

// >>> rtl/xide_core.v
// Functional notes
// - 01101rrr xors working register into accumulator
// - 01100101 xors direct byte into accumulator
// - 0110011i xors pointer-indirect RAM byte into accumulator
// - 01100100 xors immediate byte into accumulator
// - 01100010 xors accumulator into direct byte
// - Operand reads never touch program space
// - Program space 64K, low 4K/8K on-chip
// - External data 64K, only by external_data_move
// - On-chip RAM 128 or 256 bytes plus SFRs
// - Low 128 RAM bytes direct and indirect reachable
// - No program status flag changes
// - Port destinations read output latch, not pins
`timescale 1ns/1ps
`include "xide_defines.vh"
module xide_core #(
    parameter LARGE = 1'b0
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire instr_valid_i,
    input wire [7:0] opcode_i,
    input wire [7:0] operand_i,
    input wire [2:0] bank_sel_i,
    input wire sfr_we_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] port_pins_i,
    input wire ext_valid_i,
    input wire ext_write_i,
    input wire [15:0] ext_addr_i,
    input wire [7:0] ext_wdata_i,
    output wire [7:0] acc_o,
    output wire [7:0] psw_flags_o,
    output wire done_o,
    output wire illegal_o,
    output wire [7:0] wr_addr_o,
    output wire [7:0] wr_data_o,
    output wire wr_en_o,
    output wire ext_req_o,
    output wire ext_wr_o,
    output wire [15:0] ext_addr_o,
    output wire [7:0] ext_wdata_o,
    output wire [15:0] prog_onchip_limit_o
);
    // Internal RAM and the direct-addressed SPECIAL_FUNCTION_SPACE space are kept here; program space is not
    reg [7:0] ram_q [0:255];
    reg [7:0] sfr_q [0:127];
    // Pin levels are captured only; no operand is ever taken from them
    reg [7:0] pin_q;

    reg [7:0] acc_q;
    reg [7:0] acc_d;
    reg [7:0] psw_q;
    reg [7:0] psw_d;
    reg done_q;
    reg done_d;
    reg illegal_q;
    reg illegal_d;
    reg wr_en_q;
    reg wr_en_d;
    reg [7:0] wr_addr_q;
    reg [7:0] wr_addr_d;
    reg [7:0] wr_data_q;
    reg [7:0] wr_data_d;
    reg ext_req_q;
    reg ext_req_d;
    reg ext_wr_q;
    reg ext_wr_d;
    reg [15:0] ext_addr_q;
    reg [15:0] ext_addr_d;
    reg [7:0] ext_wdata_q;
    reg [7:0] ext_wdata_d;
    reg [15:0] limit_q;
    reg [15:0] limit_d;

    // Operand form of an opcode; CLS_NONE marks anything outside the group
    localparam [2:0] CLS_NONE = 3'h0;
    localparam [2:0] CLS_REG = 3'h1;
    localparam [2:0] CLS_DIR = 3'h2;
    localparam [2:0] CLS_IND = 3'h3;
    localparam [2:0] CLS_IMM = 3'h4;
    localparam [2:0] CLS_DST = 3'h5;

    function [2:0] op_class;
        input [7:0] op;
        begin
            if (op[7:3] == `XIDE_OP_REG_HI) begin
                op_class = CLS_REG;
            end else if (op == `XIDE_OP_DIR) begin
                op_class = CLS_DIR;
            end else if (op[7:1] == `XIDE_OP_IND_HI) begin
                op_class = CLS_IND;
            end else if (op == `XIDE_OP_IMM) begin
                op_class = CLS_IMM;
            end else if (op == `XIDE_OP_DST) begin
                op_class = CLS_DST;
            end else begin
                op_class = CLS_NONE;
            end
        end
    endfunction

    function is_xor;
        input [7:0] op;
        begin
            is_xor = (op_class(op) != CLS_NONE);
        end
    endfunction

    function is_port;
        input [7:0] a;
        begin
            is_port = (a == `XIDE_SFR_P0) || (a == `XIDE_SFR_P1) ||
                      (a == `XIDE_SFR_P2) || (a == `XIDE_SFR_P3);
        end
    endfunction

    function is_sfr;
        input [7:0] a;
        begin
            is_sfr = (a >= `XIDE_SFR_BASE);
        end
    endfunction

    function is_acc;
        input [7:0] a;
        begin
            is_acc = (a == `XIDE_SFR_ACC);
        end
    endfunction

    wire [8:0] ram_size = LARGE ? `XIDE_RAM_LARGE : `XIDE_RAM_SMALL;
    wire [7:0] reg_addr = {`XIDE_REG_PAD, bank_sel_i[1:0], opcode_i[2:0]};
    wire [7:0] ptr_addr = {`XIDE_REG_PAD, bank_sel_i[1:0], `XIDE_PTR_PAD, opcode_i[0]};
    wire [7:0] ptr_val = ram_q[ptr_addr];
    wire [2:0] op_cls = op_class(opcode_i);
    wire op_xor = is_xor(opcode_i);
    wire go = instr_valid_i;

    // Direct reads: below the SPECIAL_FUNCTION_SPACE base is RAM, above is SPECIAL_FUNCTION_SPACE; ports read latch
    reg [7:0] direct_val;
    always @* begin
        if (!is_sfr(operand_i)) begin
            direct_val = ram_q[operand_i];
        end else if (is_acc(operand_i)) begin
            direct_val = acc_q;
        end else if (is_port(operand_i)) begin
            direct_val = sfr_q[operand_i[6:0]];
        end else begin
            direct_val = sfr_q[operand_i[6:0]];
        end
    end

    // Indirect reads above the fitted RAM size return zero
    reg [7:0] ind_val;
    always @* begin
        if ({1'b0, ptr_val} < ram_size) begin
            ind_val = ram_q[ptr_val];
        end else begin
            ind_val = `XIDE_ZERO_BYTE;
        end
    end

    reg [7:0] src;
    reg acc_wr;
    reg dst_wr;
    always @* begin
        src = `XIDE_ZERO_BYTE;
        acc_wr = 1'b0;
        dst_wr = 1'b0;
        case (op_cls)
            CLS_REG: begin
                src = ram_q[reg_addr];
                acc_wr = 1'b1;
            end
            CLS_DIR: begin
                src = direct_val;
                acc_wr = 1'b1;
            end
            CLS_IND: begin
                src = ind_val;
                acc_wr = 1'b1;
            end
            CLS_IMM: begin
                src = operand_i;
                acc_wr = 1'b1;
            end
            CLS_DST: begin
                src = direct_val;
                dst_wr = 1'b1;
            end
            default: begin
                src = `XIDE_ZERO_BYTE;
            end
        endcase
    end

    wire [7:0] result = src ^ acc_q;
    wire dst_ram = go && dst_wr && !is_sfr(operand_i);
    wire dst_sfr = go && dst_wr && is_sfr(operand_i) && !is_acc(operand_i);
    wire dst_acc = go && dst_wr && is_acc(operand_i);

    // An instruction write wins over a preload write in the same cycle
    always @(posedge clock_i) begin
        if (dst_ram) begin
            ram_q[operand_i] <= result;
        end else if (sfr_we_i && !is_sfr(sfr_addr_i)) begin
            ram_q[sfr_addr_i] <= sfr_wdata_i;
        end
    end

    always @(posedge clock_i) begin
        if (dst_sfr) begin
            sfr_q[operand_i[6:0]] <= result;
        end else if (sfr_we_i && is_sfr(sfr_addr_i)) begin
            sfr_q[sfr_addr_i[6:0]] <= sfr_wdata_i;
        end
    end

    always @(posedge clock_i) begin
        pin_q <= port_pins_i;
    end

    // Accumulator: instruction result first, then a preload write
    always @* begin
        acc_d = acc_q;
        if (go && acc_wr) begin
            acc_d = result;
        end else if (dst_acc) begin
            // Xor of the accumulator with itself clears it
            acc_d = result;
        end else if (sfr_we_i && is_acc(sfr_addr_i)) begin
            acc_d = sfr_wdata_i;
        end
    end

    // Flags are passed through untouched
    always @* begin
        psw_d = psw_q;
    end

    always @* begin
        done_d = go && op_xor;
        illegal_d = go && !op_xor;
    end

    always @* begin
        wr_en_d = go && dst_wr;
        wr_addr_d = operand_i;
        wr_data_d = result;
    end

    // External data only via the dedicated move request
    always @* begin
        ext_req_d = ext_valid_i;
        ext_wr_d = ext_valid_i && ext_write_i;
        ext_addr_d = ext_addr_q;
        ext_wdata_d = ext_wdata_q;
        if (ext_valid_i) begin
            ext_addr_d = ext_addr_i;
            ext_wdata_d = ext_wdata_i;
        end
    end

    always @* begin
        if (LARGE) begin
            limit_d = `XIDE_PROG_ONCHIP_LARGE;
        end else begin
            limit_d = `XIDE_PROG_ONCHIP_SMALL;
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_q <= `XIDE_ZERO_BYTE;
            psw_q <= `XIDE_ZERO_BYTE;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            psw_q <= psw_d;
            done_q <= done_d;
            illegal_q <= illegal_d;
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_en_q <= 1'b0;
            wr_addr_q <= `XIDE_ZERO_BYTE;
            wr_data_q <= `XIDE_ZERO_BYTE;
        end else begin
            wr_en_q <= wr_en_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_req_q <= 1'b0;
            ext_wr_q <= 1'b0;
            ext_addr_q <= `XIDE_ZERO_WORD;
            ext_wdata_q <= `XIDE_ZERO_BYTE;
        end else begin
            ext_req_q <= ext_req_d;
            ext_wr_q <= ext_wr_d;
            ext_addr_q <= ext_addr_d;
            ext_wdata_q <= ext_wdata_d;
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            limit_q <= `XIDE_ZERO_WORD;
        end else begin
            limit_q <= limit_d;
        end
    end

    assign acc_o = acc_q;
    assign psw_flags_o = psw_q;
    assign done_o = done_q;
    assign illegal_o = illegal_q;
    assign wr_addr_o = wr_addr_q;
    assign wr_data_o = wr_data_q;
    assign wr_en_o = wr_en_q;
    assign ext_req_o = ext_req_q;
    assign ext_wr_o = ext_wr_q;
    assign ext_addr_o = ext_addr_q;
    assign ext_wdata_o = ext_wdata_q;
    assign prog_onchip_limit_o = limit_q;
endmodule

// >>> bench/xide_fetch_model.sv
`timescale 1ns/1ps
module xide_fetch_model (
    input wire clock_i,
    output logic iv_o = 0,
    output logic [7:0] op_o = 0,
    output logic [7:0] opr_o = 0,
    output logic we_o = 0,
    output logic [7:0] wa_o = 0,
    output logic [7:0] wd_o = 0
);
    // Released lines show the inverse so stale values cannot pass
    task issue(input [7:0] op, input [7:0] opr);
        @(negedge clock_i);
        {iv_o, op_o, opr_o} = {1'b1, op, opr};
        @(negedge clock_i);
        {iv_o, op_o, opr_o} = {1'b0, ~op, ~opr};
    endtask
    task poke(input [7:0] a, input [7:0] d);
        @(negedge clock_i);
        {we_o, wa_o, wd_o} = {1'b1, a, d};
        @(negedge clock_i);
        {we_o, wa_o, wd_o} = {1'b0, ~a, ~d};
    endtask
endmodule

// >>> bench/xide_core_assertions.sv
`timescale 1ns/1ps
`include "xide_defines.vh"
module xide_core_assertions #(parameter LARGE = 1'b0) (
    input wire clock_i,
    input wire reset_n_i,
    input wire instr_valid_i,
    input wire [7:0] opcode_i,
    input wire [7:0] operand_i,
    input wire ext_valid_i,
    input wire ext_write_i,
    input wire [15:0] ext_addr_i,
    input wire [7:0] acc_o,
    input wire [7:0] psw_flags_o,
    input wire done_o,
    input wire illegal_o,
    input wire [7:0] wr_addr_o,
    input wire wr_en_o,
    input wire ext_req_o,
    input wire ext_wr_o,
    input wire [15:0] ext_addr_o,
    input wire [15:0] prog_onchip_limit_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    wire v = instr_valid_i;
    wire xo = opcode_i[7:3] == `XIDE_OP_REG_HI || opcode_i[7:1] == `XIDE_OP_IND_HI
        || opcode_i == `XIDE_OP_IMM || opcode_i == `XIDE_OP_DIR || opcode_i == `XIDE_OP_DST;
    a_psw_untouched: assert property (psw_flags_o == 8'h00)
        else $error("flags changed");
    a_imm_result: assert property (v && opcode_i == `XIDE_OP_IMM |=>
        done_o && acc_o == ($past(acc_o) ^ $past(operand_i))) else $error("imm xor wrong");
    a_dst_write: assert property (v && opcode_i == `XIDE_OP_DST && operand_i != 8'he0 |=>
        wr_en_o && wr_addr_o == $past(operand_i) && $stable(acc_o)) else $error("dst bad");
    a_reg_single: assert property (v && opcode_i[7:3] == 5'h0d |=> done_o)
        else $error("reg form late");
    a_mem_single: assert property (v && (opcode_i[7:1] == 7'h33 || opcode_i == 8'h65) |=> done_o)
        else $error("mem form late");
    a_refuse_other: assert property (v && !xo |=> illegal_o && !done_o && $stable(acc_o))
        else $error("non-xor executed");
    a_idle_quiet: assert property (!v |=> !done_o && !wr_en_o)
        else $error("spurious done");
    a_ext_copy: assert property (ext_valid_i |=> ext_req_o && ext_wr_o == $past(ext_write_i)
        && ext_addr_o == $past(ext_addr_i)) else $error("ext request lost");
    a_prog_limit: assert property (1'b1 |=> prog_onchip_limit_o == (LARGE ? 16'h2000 : 16'h1000))
        else $error("limit wrong");
    cover property (done_o);
    cover property (wr_en_o);
    cover property (illegal_o);
endmodule
bind xide_core xide_core_assertions #(.LARGE(LARGE)) u_chk (.*);

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clock_i = 0, reset_n_i = 0, ev = 0, ewr = 0, iv, we, done, ill, wen, er, ew;
    logic [7:0] op, opr, sa, sd, acc, wa, wd, psw, ewd;
    logic [15:0] ea, lim;
    int n_errors = 0, samples_checked = 0;
    initial forever #50 clock_i = ~clock_i;
    xide_fetch_model u_fetch (.clock_i(clock_i), .iv_o(iv), .op_o(op), .opr_o(opr),
        .we_o(we), .wa_o(sa), .wd_o(sd));
    xide_core dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .instr_valid_i(iv),
        .opcode_i(op), .operand_i(opr), .bank_sel_i(3'h1), .sfr_we_i(we), .sfr_addr_i(sa),
        .sfr_wdata_i(sd), .port_pins_i(8'hf0), .ext_valid_i(ev), .ext_write_i(ewr),
        .ext_addr_i(16'h1234), .ext_wdata_i(8'h5c), .acc_o(acc), .psw_flags_o(psw),
        .done_o(done), .illegal_o(ill), .wr_addr_o(wa), .wr_data_o(wd), .wr_en_o(wen),
        .ext_req_o(er), .ext_wr_o(ew), .ext_addr_o(ea), .ext_wdata_o(ewd),
        .prog_onchip_limit_o(lim));
    task chk(input [15:0] g, input [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task run(input [7:0] o, input [7:0] d, input [7:0] e);
        u_fetch.issue(o, d);
        chk({7'h00, done, acc}, {8'h01, e});
    endtask
    task t_reg;
        u_fetch.poke(8'he0, 8'hc3);
        u_fetch.poke(8'h08, 8'haa);
        u_fetch.poke(8'h0f, 8'h11);
        run(8'h68, 8'h00, 8'h69);
        run(8'h6f, 8'h00, 8'h78);
    endtask
    task t_mem;
        u_fetch.poke(8'h30, 8'h5a);
        u_fetch.poke(8'h09, 8'h30);
        run(8'h65, 8'h30, 8'h22);
        run(8'h67, 8'h00, 8'h78);
        run(8'h64, 8'hff, 8'h87);
    endtask
    task t_dst;
        u_fetch.issue(8'h62, 8'h30);
        chk({7'h00, wen, wa}, 16'h0130);
        chk({8'h00, wd}, 16'h00dd);
        run(8'h65, 8'h30, 8'h5a);
        u_fetch.poke(8'h90, 8'h0f);
        u_fetch.issue(8'h62, 8'h90);
        chk({8'h00, wd}, 16'h0055);
        u_fetch.issue(8'h00, 8'h00);
        chk({7'h00, ill, acc}, 16'h015a);
        chk({8'h00, psw}, 16'h0000);
        run(8'h66, 8'h00, 8'h5a);
        run(8'h62, 8'he0, 8'h00);
    endtask
    task t_ext;
        @(negedge clock_i) {ev, ewr} = 2'b11;
        @(negedge clock_i) {ev, ewr} = 2'b10;
        chk({14'h0, er, ew}, 16'h0003);
        chk(ea, 16'h1234);
        chk({8'h00, ewd}, 16'h005c);
        @(negedge clock_i) ev = 0;
        chk({14'h0, er, ew}, 16'h0002);
        chk(lim, 16'h1000);
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock_i);
        reset_n_i = 1;
        t_reg();
        t_mem();
        t_dst();
        t_ext();
        end_of_test();
    end
endmodule
